/* File: design/swt_link.sv */
/*
 * Slave end of the single-wire sensor link: reset, presence, identification
 * commands and the nine-byte scratchpad with its check byte.
 * Assumes dqIn synchronous to mclk and the wire resolved outside from dqOe.
 */
// Functional notes
// RL1 - power-up temperature bytes are 50h and 05h
// RL2 - reserved bytes five and seven fixed FFh, 10h
// RL3 - limits and config from nonvolatile; check byte computed
// RL4 - config: resolution bits 6,5, rest fixed
// RL5 - resolution selects matching longest conversion time
// RL6 - resolution defaults to 12-bit
// RL7 - byte eight is check over bytes 0-7
// RL8 - code top byte checks low 56 bits
// RL9 - polynomial x8+x5+x4+1, zero start, lsb first
// RL10 - master verifies by shifting data plus check
// RL11 - check mismatch never blocks command flow
// RL12 - device is slave only, never initiates
// RL13 - all bytes travel least significant bit first
// RL14 - open-drain drive, released when not sending
// RL15 - recovery between bits may last indefinitely
// RL16 - low beyond 480us resets the bus logic
// RL17 - every transaction starts reset then presence
// RL18 - ignore transaction unless steps come in order
// RL19 - after searches master must reinitialize
// RL20 - five eight-bit identification commands recognised
// RL21 - read-identification sends all 64 code bits
// RL22 - search supports elimination across repeated cycles
// RL23 - code: family low, serial, check top
// RL24 - match 55h: respond only on exact code
// RL25 - skip CCh addresses device without code
// RL26 - alarm search joins only with alarm set
// RL27 - search bit: send, complement, read, drop out
// RL28 - slot and reset durations are parameters
`timescale 1ns/1ps
`default_nettype none

module swt_link #(
    parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
    parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001, // arbitrary value
    parameter logic [7:0] RSVD6_VALUE = swt_pkg::RSVD6_DEFAULT,
    parameter int RESET_LOW_CYC = swt_pkg::RESET_LOW_CYC, // RL28
    parameter int SAMPLE_CYC = swt_pkg::SAMPLE_CYC,
    parameter int TX_HOLD_CYC = swt_pkg::TX_HOLD_CYC,
    parameter int PRES_WAIT_CYC = swt_pkg::PRES_WAIT_CYC,
    parameter int PRES_LEN_CYC = swt_pkg::PRES_LEN_CYC,
    parameter int CONV9_CYC = swt_pkg::CONV9_CYC,
    parameter int CONV10_CYC = swt_pkg::CONV10_CYC,
    parameter int CONV11_CYC = swt_pkg::CONV11_CYC,
    parameter int CONV12_CYC = swt_pkg::CONV12_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic dqIn,
    input wire logic [7:0] nvUpper,
    input wire logic [7:0] nvLower,
    input wire logic [7:0] nvConfig,
    input wire logic tempWrite,
    input wire logic [15:0] tempWord,
    input wire logic alarmFlag,
    output logic dqOut,
    output logic dqOe,
    output logic [1:0] resSel,
    output logic [31:0] convCycles,
    output logic [7:0] upperLimit,
    output logic [7:0] lowerLimit
);
    localparam logic [swt_pkg::CNT_W-1:0] RESET_LIM = swt_pkg::CNT_W'(RESET_LOW_CYC);
    localparam logic [swt_pkg::CNT_W-1:0] SAMPLE_AT = swt_pkg::CNT_W'(SAMPLE_CYC);
    localparam logic [swt_pkg::CNT_W-1:0] HOLD_END = swt_pkg::CNT_W'(TX_HOLD_CYC);
    localparam logic [swt_pkg::CNT_W-1:0] PRES_START = swt_pkg::CNT_W'(PRES_WAIT_CYC);
    localparam logic [swt_pkg::CNT_W-1:0] PRES_END = swt_pkg::CNT_W'(PRES_WAIT_CYC + PRES_LEN_CYC);

    // crc8 shifted lsb first from a zero start over the low nbits of data
    function automatic logic [7:0] crc8(input logic [63:0] data, input int nbits);
        logic [7:0] c;
        logic fb;
        c = 8'h00; // RL9
        fb = 1'b0;
        for (int i = 0; i < 64; i++) begin
            if (i < nbits) begin
                fb = c[0] ^ data[i]; // RL9
                c = {1'b0, c[7:1]};
                if (fb) begin
                    c = c ^ swt_pkg::CRC_POLY_REFL;
                end
            end
        end
        return c;
    endfunction : crc8

    // conversion time limit for a resolution code
    function automatic logic [31:0] conv_limit(input logic [1:0] r);
        case (r)
            2'h0: conv_limit = 32'(CONV9_CYC); // RL5
            2'h1: conv_limit = 32'(CONV10_CYC); // RL5
            2'h2: conv_limit = 32'(CONV11_CYC); // RL5
            default: conv_limit = 32'(CONV12_CYC); // RL5
        endcase
    endfunction : conv_limit

    swt_pkg::swt_state_type r_reg;
    swt_pkg::swt_state_type r_next;
    logic [63:0] romCode;
    logic [7:0] cfgByte;
    logic [63:0] spadData;
    logic [71:0] spadImage;
    logic fallEdge;
    logic riseEdge;

    // identification code: family low, serial middle, check on top
    assign romCode[55:0] = {SERIAL_NUMBER, FAMILY_CODE}; // RL23
    assign romCode[63:56] = crc8({8'h00, SERIAL_NUMBER, FAMILY_CODE}, swt_pkg::ROM_CRC_BITS); // RL8

    // fixed bits of the config byte are rebuilt here, never stored
    always_comb begin
        cfgByte = {3'h0, swt_pkg::CFG_LOW_ONES}; // RL4
        cfgByte[swt_pkg::CFG_RES_HI_BIT] = r_reg.res[1]; // RL4
        cfgByte[swt_pkg::CFG_RES_LO_BIT] = r_reg.res[0]; // RL4
    end

    // scratchpad image; check byte follows bytes 0-7 combinationally
    assign spadData = {swt_pkg::RSVD7_VALUE, RSVD6_VALUE, swt_pkg::RSVD5_VALUE, // RL2
                       cfgByte, r_reg.lower, r_reg.upper, r_reg.temp};
    assign spadImage = {crc8(spadData, 64), spadData}; // RL7

    assign fallEdge = r_reg.prevDq & ~dqIn;
    assign riseEdge = ~r_reg.prevDq & dqIn;

    // the whole slave: reset watch, slot engine and command sequencer
    always_comb begin
        logic txBit;
        logic txWant;
        logic rxBit;
        logic slotDone;
        txBit = 1'b1;
        txWant = 1'b0;
        rxBit = dqIn;
        slotDone = 1'b0;
        r_next = r_reg;
        r_next.prevDq = dqIn;
        r_next.dqOut = 1'b0; // RL14

        // power-up load of nonvolatile copy, one clock after release
        if (!r_reg.loaded) begin
            r_next.loaded = 1'b1;
            r_next.upper = nvUpper; // RL3
            r_next.lower = nvLower; // RL3
            r_next.res = {nvConfig[swt_pkg::CFG_RES_HI_BIT], nvConfig[swt_pkg::CFG_RES_LO_BIT]}; // RL3
        end

        // conversion results overwrite the power-up reading
        if (tempWrite) begin
            r_next.temp = tempWord;
        end
        r_next.conv = conv_limit(r_reg.res); // RL5

        // bit to send in the coming slot, if any
        case (r_reg.phase)
            swt_pkg::PH_READ_ID: begin
                txWant = 1'b1;
                txBit = romCode[r_reg.bitIdx[5:0]]; // RL21
            end
            swt_pkg::PH_SEARCH: begin
                if (r_reg.searchStep == 2'h0) begin
                    txWant = 1'b1;
                    txBit = romCode[r_reg.bitIdx[5:0]]; // RL27
                end else if (r_reg.searchStep == 2'h1) begin
                    txWant = 1'b1;
                    txBit = ~romCode[r_reg.bitIdx[5:0]]; // RL27
                end
            end
            swt_pkg::PH_READ_SPAD: begin
                txWant = 1'b1;
                txBit = spadImage[r_reg.bitIdx]; // RL13
            end
            default: txWant = 1'b0;
        endcase

        // low-time watch; a long low outranks everything else
        if (!dqIn) begin
            if (r_reg.lowCnt != {swt_pkg::CNT_W{1'b1}}) begin
                r_next.lowCnt = r_reg.lowCnt + 1'b1;
            end
        end else begin
            r_next.lowCnt = '0;
        end

        // slot timing starts only on the master's falling edge
        if (r_reg.inSlot) begin
            r_next.slotCnt = r_reg.slotCnt + 1'b1;
            if (r_reg.slotCnt == SAMPLE_AT) begin
                slotDone = 1'b1;
            end
            if (r_reg.slotCnt >= HOLD_END) begin
                r_next.dqOe = 1'b0; // RL14
                r_next.inSlot = 1'b0;
            end
        end else if (fallEdge && r_reg.phase != swt_pkg::PH_WAIT_RESET
                     && r_reg.phase != swt_pkg::PH_PRESENCE) begin
            // idle-high gaps between slots are unbounded
            r_next.inSlot = 1'b1; // RL15
            r_next.slotCnt = '0;
            r_next.slotTx = txWant;
            r_next.dqOe = txWant & ~txBit; // RL14
        end

        // sequencer acts at the sample point of each slot
        if (slotDone) begin
            case (r_reg.phase)
                swt_pkg::PH_ROM_CMD: begin
                    r_next.cmd = {rxBit, r_reg.cmd[7:1]}; // RL13
                    r_next.bitIdx = r_reg.bitIdx + 1'b1;
                    if (r_reg.bitIdx == 7'd7) begin
                        r_next.bitIdx = '0;
                        r_next.searchStep = 2'h0;
                        r_next.miss = 1'b0;
                        case ({rxBit, r_reg.cmd[7:1]}) // RL20
                            swt_pkg::CMD_READ_ID: r_next.phase = swt_pkg::PH_READ_ID; // RL21
                            swt_pkg::CMD_MATCH: r_next.phase = swt_pkg::PH_MATCH; // RL24
                            swt_pkg::CMD_SKIP: r_next.phase = swt_pkg::PH_FUNC_CMD; // RL25
                            swt_pkg::CMD_SEARCH: r_next.phase = swt_pkg::PH_SEARCH; // RL22
                            swt_pkg::CMD_ALARM_SEARCH: begin
                                r_next.phase = alarmFlag ? swt_pkg::PH_SEARCH // RL26
                                                         : swt_pkg::PH_WAIT_RESET;
                            end
                            default: r_next.phase = swt_pkg::PH_WAIT_RESET; // RL18
                        endcase
                    end
                end
                swt_pkg::PH_READ_ID: begin
                    r_next.bitIdx = r_reg.bitIdx + 1'b1;
                    if (r_reg.bitIdx == 7'(swt_pkg::ROM_BITS - 1)) begin
                        r_next.bitIdx = '0;
                        r_next.phase = swt_pkg::PH_FUNC_CMD; // RL21
                    end
                end
                swt_pkg::PH_MATCH: begin
                    r_next.bitIdx = r_reg.bitIdx + 1'b1;
                    if (rxBit != romCode[r_reg.bitIdx[5:0]]) begin
                        r_next.miss = 1'b1; // RL24
                    end
                    if (r_reg.bitIdx == 7'(swt_pkg::ROM_BITS - 1)) begin
                        r_next.bitIdx = '0;
                        // any differing bit leaves the device waiting for reset
                        if (r_reg.miss || rxBit != romCode[r_reg.bitIdx[5:0]]) begin
                            r_next.phase = swt_pkg::PH_WAIT_RESET; // RL24
                        end else begin
                            r_next.phase = swt_pkg::PH_FUNC_CMD; // RL24
                        end
                    end
                end
                swt_pkg::PH_SEARCH: begin
                    if (r_reg.searchStep != 2'h2) begin
                        r_next.searchStep = r_reg.searchStep + 1'b1; // RL27
                    end else begin
                        r_next.searchStep = 2'h0;
                        r_next.bitIdx = r_reg.bitIdx + 1'b1;
                        if (rxBit != romCode[r_reg.bitIdx[5:0]]) begin
                            r_next.phase = swt_pkg::PH_WAIT_RESET; // RL27
                        end else if (r_reg.bitIdx == 7'(swt_pkg::ROM_BITS - 1)) begin
                            // search always ends the transaction
                            r_next.phase = swt_pkg::PH_WAIT_RESET; // RL19
                        end
                    end
                end
                swt_pkg::PH_FUNC_CMD: begin
                    r_next.cmd = {rxBit, r_reg.cmd[7:1]}; // RL13
                    r_next.bitIdx = r_reg.bitIdx + 1'b1;
                    if (r_reg.bitIdx == 7'd7) begin
                        r_next.bitIdx = '0;
                        case ({rxBit, r_reg.cmd[7:1]})
                            swt_pkg::CMD_READ_SPAD: r_next.phase = swt_pkg::PH_READ_SPAD;
                            swt_pkg::CMD_WRITE_SPAD: r_next.phase = swt_pkg::PH_WRITE_SPAD;
                            default: r_next.phase = swt_pkg::PH_WAIT_RESET;
                        endcase
                    end
                end
                swt_pkg::PH_READ_SPAD: begin
                    // the check byte is sent as is; the master judges it
                    r_next.bitIdx = r_reg.bitIdx + 1'b1; // RL11
                    if (r_reg.bitIdx == 7'(swt_pkg::SP_BITS - 1)) begin
                        r_next.phase = swt_pkg::PH_WAIT_RESET;
                    end
                end
                swt_pkg::PH_WRITE_SPAD: begin
                    r_next.cmd = {rxBit, r_reg.cmd[7:1]}; // RL13
                    r_next.bitIdx = r_reg.bitIdx + 1'b1;
                    // each byte commits when complete; partial bytes are dropped
                    if (r_reg.bitIdx[2:0] == 3'h7) begin
                        case (r_reg.bitIdx[4:3])
                            2'h0: r_next.upper = {rxBit, r_reg.cmd[7:1]};
                            2'h1: r_next.lower = {rxBit, r_reg.cmd[7:1]};
                            default: begin
                                r_next.res = {r_reg.cmd[swt_pkg::CFG_RES_HI_BIT + 1], // RL4
                                              r_reg.cmd[swt_pkg::CFG_RES_LO_BIT + 1]};
                                r_next.phase = swt_pkg::PH_WAIT_RESET;
                            end
                        endcase
                    end
                end
                default: r_next.phase = r_reg.phase;
            endcase
        end

        // presence pulse after the master's reset pulse ends
        if (r_reg.phase == swt_pkg::PH_PRESENCE) begin
            r_next.presCnt = r_reg.presCnt + 1'b1;
            if (r_reg.presCnt == PRES_START) begin
                r_next.dqOe = 1'b1; // RL17
            end
            if (r_reg.presCnt == PRES_END) begin
                r_next.dqOe = 1'b0; // RL14
                r_next.phase = swt_pkg::PH_ROM_CMD; // RL18
                r_next.bitIdx = '0;
            end
        end

        // long low: drop everything, answer with presence on release
        if (r_reg.lowCnt >= RESET_LIM && !dqIn && !r_reg.dqOe) begin
            r_next.rstSeen = 1'b1; // RL16
            r_next.phase = swt_pkg::PH_WAIT_RESET; // RL16
            r_next.inSlot = 1'b0;
            r_next.dqOe = 1'b0;
        end else if (riseEdge && r_reg.rstSeen) begin
            r_next.rstSeen = 1'b0;
            r_next.phase = swt_pkg::PH_PRESENCE; // RL17
            r_next.presCnt = '0;
            r_next.inSlot = 1'b0;
        end
    end

    // single state register; only constants under reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r_reg <= '0;
            r_reg.phase <= swt_pkg::PH_WAIT_RESET; // RL12
            r_reg.prevDq <= 1'b1;
            r_reg.temp <= {swt_pkg::TEMP_HI_PWRUP, swt_pkg::TEMP_LO_PWRUP}; // RL1
            r_reg.res <= swt_pkg::RES_DEFAULT; // RL6
            r_reg.conv <= 32'(CONV12_CYC);
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from the state register
    assign dqOut = r_reg.dqOut;
    assign dqOe = r_reg.dqOe;
    assign resSel = r_reg.res;
    assign convCycles = r_reg.conv;
    assign upperLimit = r_reg.upper;
    assign lowerLimit = r_reg.lower;
endmodule : swt_link

`default_nettype wire

/* File: inc/swt_pkg.sv */
/*
 * Constants, command codes and state record of the sensor slave.
 * Assumes a 40 MHz system clock.
 */
package swt_pkg;
    // timing in clock cycles, ns figures inside the expressions
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_LOW_CYC = (480_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_CYC = 15_000 / CLK_PERIOD_NS;
    localparam int TX_HOLD_CYC = 45_000 / CLK_PERIOD_NS;
    localparam int PRES_WAIT_CYC = 30_000 / CLK_PERIOD_NS;
    localparam int PRES_LEN_CYC = 120_000 / CLK_PERIOD_NS;
    localparam int CONV9_CYC = 93_750_000 / CLK_PERIOD_NS;
    localparam int CONV10_CYC = 187_500_000 / CLK_PERIOD_NS;
    localparam int CONV11_CYC = 375_000_000 / CLK_PERIOD_NS;
    localparam int CONV12_CYC = 750_000_000 / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    // scratchpad byte offsets and fixed contents
    localparam int SP_TEMP_LO = 0;
    localparam int SP_TEMP_HI = 1;
    localparam int SP_UPPER = 2;
    localparam int SP_LOWER = 3;
    localparam int SP_CFG = 4;
    localparam int SP_RSVD5 = 5;
    localparam int SP_RSVD6 = 6;
    localparam int SP_RSVD7 = 7;
    localparam int SP_CRC = 8;
    localparam int SP_BITS = 72;
    localparam logic [7:0] TEMP_LO_PWRUP = 8'h50;
    localparam logic [7:0] TEMP_HI_PWRUP = 8'h05;
    localparam logic [7:0] RSVD5_VALUE = 8'hFF;
    localparam logic [7:0] RSVD6_DEFAULT = 8'h00;
    localparam logic [7:0] RSVD7_VALUE = 8'h10;
    localparam int CFG_RES_HI_BIT = 6;
    localparam int CFG_RES_LO_BIT = 5;
    localparam logic [4:0] CFG_LOW_ONES = 5'h1F;
    localparam logic [1:0] RES_DEFAULT = 2'h3;
    // identification code and crc
    localparam int ROM_BITS = 64;
    localparam int ROM_CRC_BITS = 56;
    localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

    // command codes
    localparam logic [7:0] CMD_SEARCH = 8'hF0;
    localparam logic [7:0] CMD_READ_ID = 8'h33;
    localparam logic [7:0] CMD_MATCH = 8'h55;
    localparam logic [7:0] CMD_SKIP = 8'hCC;
    localparam logic [7:0] CMD_ALARM_SEARCH = 8'hEC;
    localparam logic [7:0] CMD_READ_SPAD = 8'hBE;
    localparam logic [7:0] CMD_WRITE_SPAD = 8'h4E;

    typedef enum logic [3:0] {
        PH_WAIT_RESET, PH_PRESENCE, PH_ROM_CMD, PH_MATCH, PH_READ_ID,
        PH_SEARCH, PH_FUNC_CMD, PH_READ_SPAD, PH_WRITE_SPAD
    } swt_phase_type;

    typedef struct packed {
        swt_phase_type phase;
        logic prevDq;
        logic rstSeen;
        logic [CNT_W-1:0] lowCnt;
        logic [CNT_W-1:0] slotCnt;
        logic inSlot;
        logic slotTx;
        logic [CNT_W-1:0] presCnt;
        logic [6:0] bitIdx;
        logic [1:0] searchStep;
        logic miss;
        logic [7:0] cmd;
        logic [15:0] temp;
        logic [7:0] upper;
        logic [7:0] lower;
        logic [1:0] res;
        logic loaded;
        logic dqOe;
        logic dqOut;
        logic [31:0] conv;
    } swt_state_type;
endpackage : swt_pkg

/* File: dv/swt_link_chk.sv */
/*
 * Port assertions for the single-wire sensor slave.
 * Assumes dqIn is the resolved wire level and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module swt_link_chk #(
    parameter int RESET_LOW_CYC = 40,
    parameter int PRES_WAIT_CYC = 4,
    parameter int CONV9_CYC = 100
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic dqIn,
    input wire logic [7:0] nvUpper,
    input wire logic [7:0] nvLower,
    input wire logic [7:0] nvConfig,
    input wire logic dqOut,
    input wire logic dqOe,
    input wire logic [1:0] resSel,
    input wire logic [31:0] convCycles,
    input wire logic [7:0] upperLimit,
    input wire logic [7:0] lowerLimit
);
    localparam int PW_LO = PRES_WAIT_CYC;
    localparam int PW_HI = PRES_WAIT_CYC + 3;
    logic [15:0] lowRun_reg;
    logic [7:0] highRun_reg;
    logic busInit_reg;
    logic [31:0] convExp_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // line run lengths, saturating so a stuck line never wraps
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lowRun_reg <= 16'h0000;
            highRun_reg <= 8'h00;
            busInit_reg <= 1'b0;
            convExp_reg <= 32'(CONV9_CYC) << 3;
        end else begin
            lowRun_reg <= (dqIn || dqOe) ? 16'h0000 : lowRun_reg + 16'((lowRun_reg != 16'hFFFF));
            highRun_reg <= !dqIn ? 8'h00 : highRun_reg + 8'((highRun_reg != 8'hFF));
            busInit_reg <= busInit_reg || (lowRun_reg > 16'(RESET_LOW_CYC));
            convExp_reg <= 32'(CONV9_CYC) << resSel;
        end
    end
    sequence longLowEnd;
        (lowRun_reg > 16'(RESET_LOW_CYC)) ##1 dqIn;
    endsequence
    drive_low_a: assert property (dqOut == 1'b0)
        else $error("data output not at low level");
    nv_load_a: assert property ($rose(rstn) |=> resSel == nvConfig[6:5] && upperLimit == nvUpper &&
        lowerLimit == nvLower) else $error("nonvolatile copy not loaded");
    conv_map_a: assert property (convCycles == convExp_reg)
        else $error("conversion time does not follow resolution");
    hold_release_a: assert property ($rose(dqOe) |-> dqOe [*8] ##[1:4] !dqOe)
        else $error("low drive length wrong");
    slave_only_a: assert property ($rose(dqOe) |-> highRun_reg <= 8'(PRES_WAIT_CYC + 3))
        else $error("device drove without master activity");
    presence_reply_a: assert property (longLowEnd |-> ##[PW_LO:PW_HI] dqOe)
        else $error("no presence after long low");
    rom_quiet_a: assert property (!busInit_reg |-> !dqOe)
        else $error("drive before first bus reset");
    cfg_quiet_a: assert property ($changed(resSel) || $changed(upperLimit) |-> !dqOe)
        else $error("settings changed while device drives");
endmodule : swt_link_chk
bind swt_link swt_link_chk #(.RESET_LOW_CYC(RESET_LOW_CYC), .PRES_WAIT_CYC(PRES_WAIT_CYC),
    .CONV9_CYC(CONV9_CYC)) i_swt_link_chk (.mclk, .rstn, .dqIn, .nvUpper, .nvLower, .nvConfig, .dqOut,
    .dqOe, .resSel, .convCycles, .upperLimit, .lowerLimit);
`default_nettype wire

/* File: dv/swt_mst.sv */
/*
 * Bus master model: reset pulse and bit slots on the shared line.
 * Assumes dqOe pulls low and a pull-up otherwise.
 */
`timescale 1ns/1ps
`default_nettype none
module swt_mst #(
    parameter int RESET_LOW_CYC = 40
) (
    input wire logic mclk,
    input wire logic dqOe,
    output logic dqIn
);
    logic pullLow = 1'b0;
    int gapCyc = 2;
    // wired-and with pull-up, high when nobody pulls
    assign dqIn = !(pullLow || dqOe);
    // long low, release, then look for the presence pulse
    task automatic busReset(output logic pres);
        pres = 1'b0;
        @(negedge mclk);
        pullLow = 1'b1;
        repeat (RESET_LOW_CYC + 10) @(negedge mclk);
        pullLow = 1'b0;
        repeat (30) begin
            @(negedge mclk);
            pres = pres | !dqIn;
        end
    endtask : busReset
    // short low sends 1 and reads, long low sends 0
    task automatic slot(input logic b, output logic r);
        @(negedge mclk);
        pullLow = 1'b1;
        for (int i = 0; i < 14; i++) begin
            @(negedge mclk);
            if (i == 0 && b) pullLow = 1'b0;
            if (i == 5) r = dqIn;
            if (i == 9) pullLow = 1'b0;
        end
        repeat (gapCyc) @(negedge mclk);
    endtask : slot
endmodule : swt_mst
`default_nettype wire

/* File: dv/swt_link_tb_top.sv */
/*
 * Self-checking bench for the sensor slave.
 * Assumes shortened slot and reset counts.
 */
`timescale 1ns/1ps
`default_nettype none
module swt_link_tb_top;
    localparam logic [7:0] FAM = 8'hA7; // arbitrary value
    localparam logic [47:0] SER = 48'h0123_4567_89AB; // arbitrary value
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic tempWrite = 1'b0;
    logic [15:0] tempWord = 16'h0000;
    logic alarmFlag = 1'b0;
    logic dqIn, dqOe, dqOut, p, a, b;
    logic [1:0] resSel;
    logic [31:0] convCycles;
    logic [7:0] upperLimit, lowerLimit;
    logic [7:0] expUp = 8'h3C, expLo = 8'hE2;
    logic [7:0] nvUpper = 8'h3C, nvLower = 8'hE2, nvConfig = 8'h7F;
    logic [1:0] expRes = 2'b11;
    logic [15:0] temp = 16'h0550;
    logic [63:0] rom;
    logic [71:0] v;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    swt_link #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER), .RESET_LOW_CYC(40), .SAMPLE_CYC(4), .TX_HOLD_CYC(8),
        .PRES_WAIT_CYC(4), .PRES_LEN_CYC(8)) i_swt_link (.mclk, .rstn, .dqIn, .nvUpper, .nvLower, .nvConfig,
        .tempWrite, .tempWord, .alarmFlag, .dqOut, .dqOe, .resSel, .convCycles, .upperLimit, .lowerLimit);
    swt_mst i_swt_mst (.mclk, .dqOe, .dqIn);
    // x8+x5+x4+1 shifted lsb first from a zero start
    function automatic logic [7:0] crc8(input logic [71:0] d, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) === 1'b1 ? 8'h8C : 8'h00);
        return c;
    endfunction : crc8
    function automatic logic [71:0] pad();
        logic [63:0] s;
        s = {8'h10, swt_pkg::RSVD6_DEFAULT, 8'hFF, 1'b0, expRes, 5'h1F, expLo, expUp, temp};
        return {crc8({8'h00, s}, 64), s};
    endfunction : pad
    task automatic check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t: %s", $time, what);
        end
    endtask : check
    task automatic busRst();
        i_swt_mst.busReset(p);
        check(p, "presence");
    endtask : busRst
    task automatic sendByte(input logic [7:0] d);
        for (int i = 0; i < 8; i++) i_swt_mst.slot(d[i], a);
    endtask : sendByte
    task automatic readBits(input int n);
        v = '1;
        for (int i = 0; i < n; i++) i_swt_mst.slot(1'b1, v[i]);
    endtask : readBits
    task automatic pair();
        i_swt_mst.slot(1'b1, a);
        i_swt_mst.slot(1'b1, b);
    endtask : pair
    task automatic readPad();
        busRst();
        sendByte(swt_pkg::CMD_SKIP);
        sendByte(swt_pkg::CMD_READ_SPAD);
        readBits(72);
        check(v === pad(), "scratchpad image");
        check(crc8(v, 72) === 8'h00, "scratchpad check");
    endtask : readPad
    task automatic t_power();
        check(resSel === 2'b11 && convCycles === 32'(swt_pkg::CONV12_CYC), "default resolution");
        check(upperLimit === 8'h3C && lowerLimit === 8'hE2, "limits");
        readPad();
    endtask : t_power
    task automatic t_read_id();
        busRst();
        sendByte(swt_pkg::CMD_READ_ID);
        readBits(64);
        check(v[63:0] === rom && crc8(v, 64) === 8'h00, "code");
        sendByte(swt_pkg::CMD_READ_SPAD);
        readBits(72);
        check(v === pad(), "read after code");
    endtask : t_read_id
    task automatic t_write();
        for (int r = 0; r < 4; r++) begin
            expUp = 8'h3C ^ 8'(r);
            expLo = 8'hE2 + 8'(r);
            expRes = 2'(r);
            busRst();
            sendByte(swt_pkg::CMD_SKIP);
            sendByte(swt_pkg::CMD_WRITE_SPAD);
            sendByte(expUp);
            sendByte(expLo);
            sendByte({1'b1, expRes, 5'h00});
            repeat (3) @(negedge mclk);
            check(resSel === expRes && convCycles === (32'(swt_pkg::CONV9_CYC) << r), "resolution");
            readPad();
        end
    endtask : t_write
    task automatic t_temp();
        tempWord = 16'h0191;
        tempWrite = 1'b1;
        @(negedge mclk);
        tempWrite = 1'b0;
        temp = 16'h0191;
        readPad();
    endtask : t_temp
    task automatic t_match();
        for (int m = 0; m < 3; m++) begin
            i_swt_mst.gapCyc = (m == 0) ? 60 : 2;
            busRst();
            if (m < 2) sendByte(swt_pkg::CMD_MATCH);
            for (int k = 0; k < 8 && m < 2; k++) sendByte(rom[8*k +: 8] ^ {7'h00, m == 1 && k == 7});
            sendByte(swt_pkg::CMD_READ_SPAD);
            readBits(16);
            check(v[15:0] === (m == 0 ? temp : 16'hFFFF), "addressed read");
        end
    endtask : t_match
    task automatic t_search();
        busRst();
        sendByte(swt_pkg::CMD_SEARCH);
        for (int i = 0; i < 64; i++) begin
            pair();
            check(a === rom[i] && b === !rom[i], "search pair");
            i_swt_mst.slot(rom[i], a);
        end
        for (int f = 0; f < 2; f++) begin
            alarmFlag = f[0];
            busRst();
            sendByte(swt_pkg::CMD_ALARM_SEARCH);
            pair();
            check(f == 0 ? a & b : a === rom[0] && b === !rom[0], "alarm search");
        end
        i_swt_mst.slot(!rom[0], a);
        pair();
        check(a & b, "dropped out");
    endtask : t_search
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // watchdog, far above the expected run length
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        rom = {crc8({16'h0000, SER, FAM}, 56), SER, FAM};
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        t_power();
        t_read_id();
        t_write();
        t_temp();
        t_match();
        t_search();
        give_verdict();
    end
endmodule : swt_link_tb_top
`default_nettype wire
